// *** rtl/cgp_pkg.sv ***
/*
 * cgp_pkg: constants shared by the clock generator and its divider.
 * Assumes a single 40 MHz system clock; slow clocks are enable pulses.
 */
package cgp_pkg;
    localparam int CGP_CLK_MHZ = 40;
    localparam logic [7:0] CGP_PCC_RESET = 8'h03;
    localparam int CGP_PCC_CK_LSB = 0;
    localparam int CGP_PCC_CK_W = 3;
    localparam int CGP_PCC_CLS_BIT = 4;
    localparam int CGP_PCC_MCK_BIT = 6;
    localparam logic [7:0] CGP_PROTECT_KEY = 8'hA5;
    localparam int CGP_PLL_MULT = 4;
    localparam int CGP_PRE1_W = 10;
    localparam int CGP_PRE2_W = 5;
    localparam int CGP_PRE4_W = 7;
    localparam logic [2:0] CGP_SEL_SUB = 3'h6;
    localparam int CGP_WATCH_HZ = 32768;
    localparam int CGP_SUB_XT_HZ = 32768;
    localparam int CGP_SUB_RC_HZ = 20000;
    localparam int CGP_FX_HZ = 5000000;
endpackage : cgp_pkg

// *** rtl/cgp_frac_div.sv ***
/*
 * cgp_frac_div: fractional-rate enable pulse generator (accumulator).
 * Assumes en marks source ticks; out pulses at num/den of their rate.
 */
`timescale 1ns/1ps
module cgp_frac_div #(
    parameter int W = 32,
    parameter logic [W-1:0] NUM = 1,
    parameter logic [W-1:0] DEN = 2
) (
    input wire logic clk, // system clock
    input wire logic rst, // sync reset
    input wire logic en, // source tick
    output logic tick // output tick, one cycle
);
    logic [W-1:0] acc_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            acc_q <= '0;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (en) begin
                if (acc_q + NUM >= DEN) begin
                    acc_q <= acc_q + NUM - DEN;
                    tick <= 1'b1;
                end else begin
                    acc_q <= acc_q + NUM;
                end
            end
        end
    end
endmodule : cgp_frac_div

// *** rtl/cgp_clock_gen.sv ***
/*
 * cgp_clock_gen: clock generator and prescalers as enable pulses.
 * Assumes osc_tick and the subclock ticks come from pins (synced here).
 * Every clock here except the output pin is a one-cycle enable at the 40 MHz rate.
 */
// Contract
// - halt main osc: halt, or stop bit with subclock
// - pll mode gives four times main osc
// - through mode passes main osc unchanged
// - pll select bit picks the mode
// - selector: main/1..32 or subclock, seven settings
// - prescaler one: main down to /1024
// - prescaler two: main /1..32 into selector
// - system clock feeds core and output pin
// - prescaler three: fixed 32.768 kHz watch tick
// - prescaler four: osc down to /128, watchdog
// - subclock crystal or RC by option
// - control reg resets 03h, protected writes
`timescale 1ns/1ps
module cgp_clock_gen
    import cgp_pkg::*;
#(
    parameter int PRE1_W = CGP_PRE1_W,
    parameter int PRE4_W = CGP_PRE4_W
) (
    input wire logic clk, // 40 MHz system clock
    input wire logic rst, // sync reset, active high
    input wire logic osc_tick, // main osc edge marker, pin
    input wire logic sub_xt_tick, // crystal subclock marker, pin
    input wire logic sub_rc_tick, // rc subclock marker, pin
    input wire logic sub_rc_option, // option: 1 selects rc subclock
    input wire logic halt_mode, // low-power halt state
    input wire logic pll_mode_select_bit, // 1 pll, 0 through
    input wire logic [7:0] pcc_wdata, // control write data
    input wire logic pcc_we, // control write strobe
    input wire logic [7:0] protect_wdata, // protect key write data
    input wire logic protect_we, // protect key write strobe
    output logic [7:0] processor_clock_ctrl_reg, // control readback
    output logic protect_err, // write without key, pulse
    output logic main_osc_stop, // main oscillator halt
    output logic main_clk_en, // main clock tick
    output logic sys_clk_en, // internal system clock tick
    output logic system_clock_output_pin, // system clock output
    output logic [PRE1_W:0] pre1_en, // peripheral ticks /1../1024
    output logic [PRE4_W:0] pre4_en, // watchdog ticks /1../128
    output logic watch_en, // 32.768 kHz watch tick
    output logic sub_clk_en // selected subclock tick
);
    logic [2:0] osc_s_q, xt_s_q, rc_s_q;
    logic osc_rise, xt_rise, rc_rise, sub_rise;
    logic [1:0] pll_cnt_q;
    logic [PRE1_W-1:0] pre1_q;
    logic [CGP_PRE2_W-1:0] pre2_q;
    logic [PRE4_W-1:0] pre4_q;
    logic [2:0] ck_act_q;
    logic armed_q;
    logic pll_base_q;
    logic out_q;

    // two flops, then the third flop only feeds edge detection
    always_ff @(posedge clk) begin
        if (rst) begin
            osc_s_q <= '0;
            xt_s_q <= '0;
            rc_s_q <= '0;
        end else begin
            osc_s_q <= {osc_s_q[1:0], osc_tick};
            xt_s_q <= {xt_s_q[1:0], sub_xt_tick};
            rc_s_q <= {rc_s_q[1:0], sub_rc_tick};
        end
    end
    assign osc_rise = osc_s_q[1] & ~osc_s_q[2];
    assign xt_rise = xt_s_q[1] & ~xt_s_q[2];
    assign rc_rise = rc_s_q[1] & ~rc_s_q[2];
    assign sub_rise = sub_rc_option ? rc_rise : xt_rise;

    // protected write: key write arms, next write commits
    always_ff @(posedge clk) begin
        if (rst) begin
            processor_clock_ctrl_reg <= CGP_PCC_RESET;
            armed_q <= 1'b0;
            protect_err <= 1'b0;
        end else begin
            protect_err <= 1'b0;
            if (protect_we) begin
                armed_q <= (protect_wdata == CGP_PROTECT_KEY);
            end else if (pcc_we) begin
                armed_q <= 1'b0;
                if (armed_q) begin
                    processor_clock_ctrl_reg <= pcc_wdata;
                end else begin
                    protect_err <= 1'b1;
                end
            end
        end
    end

    // stop bit acts on the selection actually in use (ck_act_q), not the cls bit
    assign main_osc_stop = halt_mode |
        (processor_clock_ctrl_reg[CGP_PCC_MCK_BIT] &
         (ck_act_q == CGP_SEL_SUB));

    // pll: four ticks per osc period, spaced per_q >> 2 cycles apart (per_q = measured period less one)
    logic [7:0] per_cnt_q, per_q, ph_cnt_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            per_cnt_q <= '0;
            per_q <= '0;
        end else if (osc_rise) begin
            per_q <= per_cnt_q;
            per_cnt_q <= '0;
        end else if (per_cnt_q != 8'hFF) begin
            per_cnt_q <= per_cnt_q + 8'h01;
        end
    end
    logic pll_tick;
    always_ff @(posedge clk) begin
        if (rst) begin
            pll_cnt_q <= '0;
            ph_cnt_q <= '0;
            pll_base_q <= 1'b0;
        end else begin
            pll_base_q <= 1'b0;
            if (osc_rise) begin
                pll_cnt_q <= '0;
                ph_cnt_q <= '0;
                pll_base_q <= 1'b1;
            end else if (pll_cnt_q != 2'(CGP_PLL_MULT - 1)) begin
                if (ph_cnt_q + 8'h01 >= 8'(per_q >> 2)) begin
                    ph_cnt_q <= '0;
                    pll_cnt_q <= pll_cnt_q + 2'h1;
                    pll_base_q <= 1'b1;
                end else begin
                    ph_cnt_q <= ph_cnt_q + 8'h01;
                end
            end
        end
    end
    assign pll_tick = pll_base_q & ~main_osc_stop;
    // limitation: pll ticks are counted, not phase locked
    // after an osc restart the first period may give fewer ticks
    assign main_clk_en = pll_mode_select_bit ? pll_tick
        : (osc_rise & ~main_osc_stop);

    always_ff @(posedge clk) begin
        if (rst) begin
            pre1_q <= '0;
            pre2_q <= '0;
        end else if (main_clk_en) begin
            pre1_q <= pre1_q + 1'b1;
            pre2_q <= pre2_q + 1'b1;
        end
    end

    // tap k pulses when the low k bits roll over
    generate
        for (genvar k = 0; k <= PRE1_W; k++) begin : g_pre1
            if (k == 0) begin : g_z
                assign pre1_en[k] = main_clk_en;
            end else begin : g_n
                assign pre1_en[k] = main_clk_en & (&pre1_q[k-1:0]);
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            pre4_q <= '0;
        end else if (osc_rise) begin
            pre4_q <= pre4_q + 1'b1;
        end
    end
    generate
        for (genvar k = 0; k <= PRE4_W; k++) begin : g_pre4
            if (k == 0) begin : g_z
                assign pre4_en[k] = osc_rise;
            end else begin : g_n
                assign pre4_en[k] = osc_rise & (&pre4_q[k-1:0]);
            end
        end
    endgenerate

    cgp_frac_div #(
        .W(32),
        .NUM(32'(CGP_WATCH_HZ)),
        .DEN(32'(CGP_FX_HZ))
    ) u_watch (
        .clk(clk),
        .rst(rst),
        .en(osc_rise),
        .tick(watch_en)
    );

    assign sub_clk_en = sub_rise;

    function automatic logic pre2_tap(input logic [2:0] sel,
                                      input logic [CGP_PRE2_W-1:0] cnt,
                                      input logic en);
        logic r;
        r = 1'b0;
        case (sel)
            3'h0: r = en;
            3'h1: r = en & cnt[0];
            3'h2: r = en & (&cnt[1:0]);
            3'h3: r = en & (&cnt[2:0]);
            3'h4: r = en & (&cnt[3:0]);
            3'h5: r = en & (&cnt[4:0]);
            default: r = 1'b0;
        endcase
        return r;
    endfunction : pre2_tap

    logic [2:0] ck_req;
    logic cur_tick;
    assign ck_req = processor_clock_ctrl_reg[CGP_PCC_CK_W-1:0];
    assign cur_tick = (ck_act_q == CGP_SEL_SUB) ? sub_rise
        : pre2_tap(ck_act_q, pre2_q, main_clk_en);

    // switch only at the end of a whole output period, so no short pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            ck_act_q <= CGP_PCC_RESET[2:0];
        end else if (cur_tick && !out_q && ck_req != ck_act_q
                     && ck_req != 3'h7) begin
            ck_act_q <= ck_req;
        end
    end
    assign sys_clk_en = cur_tick;

    always_ff @(posedge clk) begin
        if (rst) begin
            out_q <= 1'b0;
        end else if (cur_tick) begin
            out_q <= ~out_q;
        end
    end
    assign system_clock_output_pin = out_q;

    // cls bit is readback only; the stop logic uses ck_act_q
    logic cls_seen;
    assign cls_seen = processor_clock_ctrl_reg[CGP_PCC_CLS_BIT];

    a_ctrl_reset: assert property (@(posedge clk)
        rst |=> processor_clock_ctrl_reg == CGP_PCC_RESET)
        else $error("control reg reset value wrong");
    a_ctrl_protect: assert property (@(posedge clk) disable iff (rst)
        pcc_we && !protect_we && !armed_q
        |=> $stable(processor_clock_ctrl_reg) && protect_err)
        else $error("unprotected write accepted");
    a_ctrl_commit: assert property (@(posedge clk) disable iff (rst)
        pcc_we && !protect_we && armed_q
        |=> processor_clock_ctrl_reg == $past(pcc_wdata))
        else $error("keyed write not applied");
    a_osc_halt: assert property (@(posedge clk) disable iff (rst)
        halt_mode |-> main_osc_stop && !main_clk_en)
        else $error("main osc runs in halt");
    a_osc_keep: assert property (@(posedge clk) disable iff (rst)
        !halt_mode && ck_act_q != CGP_SEL_SUB |-> !main_osc_stop)
        else $error("main osc stopped without subclock");
    a_mck_stop: assert property (@(posedge clk) disable iff (rst)
        processor_clock_ctrl_reg[CGP_PCC_MCK_BIT] && ck_act_q == CGP_SEL_SUB
        |-> main_osc_stop)
        else $error("stop bit ignored on subclock");
    a_thru_mode: assert property (@(posedge clk) disable iff (rst)
        !pll_mode_select_bit && !main_osc_stop
        |-> main_clk_en == osc_rise)
        else $error("through mode altered clock");
    a_pre1_top: assert property (@(posedge clk) disable iff (rst)
        pre1_en[PRE1_W] |-> main_clk_en && (&pre1_q))
        else $error("prescaler one top tap wrong");
    a_pre2_div: assert property (@(posedge clk) disable iff (rst)
        sys_clk_en && ck_act_q != CGP_SEL_SUB |-> main_clk_en)
        else $error("system tick without main tick");
    a_pre4_top: assert property (@(posedge clk) disable iff (rst)
        pre4_en[PRE4_W] |-> osc_rise && (&pre4_q))
        else $error("prescaler four top tap wrong");
    a_watch_src: assert property (@(posedge clk) disable iff (rst)
        watch_en |-> $past(osc_rise))
        else $error("watch tick without osc edge");
    a_sel_glitch: assert property (@(posedge clk) disable iff (rst)
        $changed(ck_act_q) |-> $past(cur_tick) && !$past(out_q))
        else $error("selector switched mid period");
    a_sel_seven: assert property (@(posedge clk) disable iff (rst)
        ck_req == 3'h7 |=> $stable(ck_act_q))
        else $error("reserved selector code applied");
    a_sub_sel: assert property (@(posedge clk) disable iff (rst)
        ck_act_q == CGP_SEL_SUB |-> sys_clk_en == sub_rise)
        else $error("subclock selection wrong");
    a_out_toggle: assert property (@(posedge clk) disable iff (rst)
        sys_clk_en |=> system_clock_output_pin != $past(out_q))
        else $error("clock output did not toggle");

    c_pll_on: cover property (@(posedge clk) disable iff (rst)
        pll_mode_select_bit && main_clk_en);
    c_to_sub: cover property (@(posedge clk) disable iff (rst)
        $changed(ck_act_q) && ck_act_q == CGP_SEL_SUB);
    c_good_write: cover property (@(posedge clk) disable iff (rst)
        pcc_we && armed_q);
    c_osc_stop: cover property (@(posedge clk) disable iff (rst)
        main_osc_stop && !halt_mode && !cls_seen);
    c_halt: cover property (@(posedge clk) disable iff (rst)
        halt_mode && main_osc_stop);
endmodule : cgp_clock_gen

// *** tb/cgp_osc_model.sv ***
/*
 * cgp_osc_model: main and sub oscillator waveforms feeding the generator.
 * Assumes one clk; half periods are counted in clk cycles.
 */
`timescale 1ns/1ps
module cgp_osc_model #(
    parameter int OSC_HALF = 4,
    parameter int XT_HALF = 610,
    parameter int RC_HALF = 1000
) (
    input wire logic clk, // system clock
    input wire logic osc_stop, // main oscillator halt request
    output logic osc_tick, // main oscillator waveform
    output logic sub_xt_tick, // crystal subclock waveform
    output logic sub_rc_tick // rc subclock waveform
);
    int n_osc = 0;
    int n_xt = 0;
    int n_rc = 0;
    initial begin
        osc_tick = 1'b0;
        sub_xt_tick = 1'b0;
        sub_rc_tick = 1'b0;
    end
    // a stopped oscillator rests low, so no stray edges reach the sync
    always @(posedge clk) begin
        n_osc <= (osc_stop || n_osc == OSC_HALF - 1) ? 0 : n_osc + 1;
        if (osc_stop)
            osc_tick <= 1'b0;
        else if (n_osc == OSC_HALF - 1)
            osc_tick <= ~osc_tick;
    end
    // subclock oscillators run free, both always present
    always @(posedge clk) begin
        n_xt <= (n_xt == XT_HALF - 1) ? 0 : n_xt + 1;
        n_rc <= (n_rc == RC_HALF - 1) ? 0 : n_rc + 1;
        if (n_xt == XT_HALF - 1)
            sub_xt_tick <= ~sub_xt_tick;
        if (n_rc == RC_HALF - 1)
            sub_rc_tick <= ~sub_rc_tick;
    end
endmodule : cgp_osc_model

// *** tb/tb_top.sv ***
/*
 * tb_top: self-checking bench for the clock generator, rates by counting.
 * Assumes the oscillator model runs main osc at 5 MHz (8 clk cycles).
 */
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
    import cgp_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic halt_mode = 1'b0, pll_mode_select_bit = 1'b0, sub_rc_option = 1'b0;
    logic pcc_we = 1'b0, protect_we = 1'b0;
    logic [7:0] pcc_wdata = 8'h00, protect_wdata = 8'h00;
    logic osc_tick, sub_xt_tick, sub_rc_tick, protect_err, main_osc_stop;
    logic main_clk_en, sys_clk_en, system_clock_output_pin, watch_en;
    logic sub_clk_en, err;
    logic [7:0] processor_clock_ctrl_reg, v;
    logic [31:0] r;
    logic [CGP_PRE1_W:0] pre1_en;
    logic [CGP_PRE4_W:0] pre4_en;
    logic osc_q = 1'b0, xt_q = 1'b0, rc_q = 1'b0, pin_q = 1'b0;
    int n_errors = 0, n_checks = 0, cycles = 0, seed = 32'hffd1;
    int c_osc, c_main, c_sys, c_pin, c_watch, c_sub, c_xt, c_rc;
    int c_pre1 [CGP_PRE1_W+1];
    int c_pre4 [CGP_PRE4_W+1];

    always #12.5 clk = ~clk;

    cgp_osc_model i_cgp_osc_model (.clk, .osc_stop(main_osc_stop),
        .osc_tick, .sub_xt_tick, .sub_rc_tick);
    cgp_clock_gen i_cgp_clock_gen (.clk, .rst, .osc_tick, .sub_xt_tick,
        .sub_rc_tick, .sub_rc_option, .halt_mode, .pll_mode_select_bit,
        .pcc_wdata, .pcc_we, .protect_wdata, .protect_we,
        .processor_clock_ctrl_reg, .protect_err, .main_osc_stop,
        .main_clk_en, .sys_clk_en, .system_clock_output_pin, .pre1_en,
        .pre4_en, .watch_en, .sub_clk_en);

    // counted on the falling edge, where the enables have settled
    always @(negedge clk) begin
        c_osc += int'(osc_tick && !osc_q);
        c_xt += int'(sub_xt_tick && !xt_q);
        c_rc += int'(sub_rc_tick && !rc_q);
        c_pin += int'(system_clock_output_pin != pin_q);
        c_main += int'(main_clk_en);
        c_sys += int'(sys_clk_en);
        c_sub += int'(sub_clk_en);
        c_watch += int'(watch_en);
        for (int k = 0; k <= CGP_PRE1_W; k++)
            c_pre1[k] += int'(pre1_en[k]);
        for (int k = 0; k <= CGP_PRE4_W; k++)
            c_pre4[k] += int'(pre4_en[k]);
        osc_q = osc_tick;
        xt_q = sub_xt_tick;
        rc_q = sub_rc_tick;
        pin_q = system_clock_output_pin;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 98000) begin
            n_errors++;
            report_and_stop();
        end
    end

    function automatic bit near(int g, int e, int t);
        return (g >= e - t) && (g <= e + t);
    endfunction : near

    task automatic window(int n);
        @(posedge clk);
        c_osc = 0;
        c_xt = 0;
        c_rc = 0;
        c_pin = 0;
        c_main = 0;
        c_sys = 0;
        c_sub = 0;
        c_watch = 0;
        c_pre1 = '{default: 0};
        c_pre4 = '{default: 0};
        repeat (n) @(posedge clk);
    endtask : window

    task automatic pcc_write(logic [7:0] d, bit keyed);
        if (keyed) begin
            @(posedge clk);
            protect_we <= 1'b1;
            protect_wdata <= CGP_PROTECT_KEY;
        end
        @(posedge clk);
        protect_we <= 1'b0;
        pcc_we <= 1'b1;
        pcc_wdata <= d;
        @(posedge clk);
        pcc_we <= 1'b0;
        @(negedge clk);
        err = protect_err;
        @(negedge clk);
        err |= protect_err;
    endtask : pcc_write

    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        `CHK(processor_clock_ctrl_reg, CGP_PCC_RESET)
        `CHK(system_clock_output_pin, 1'b0)
        for (int m = 0; m < 2; m++) begin
            @(posedge clk);
            pll_mode_select_bit <= m[0];
            repeat (200) @(posedge clk);
            window(2048);
            `CHK(near(c_main, c_osc * (m ? CGP_PLL_MULT : 1), m ? 4 : 1), 1'b1)
        end
        // divider sweep in pll mode, then subclock twice with random source
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            @(posedge clk);
            sub_rc_option <= r[8];
            v = (r[7:0] & 8'hB8) | ((i < 6) ? i[7:0] : 8'h06);
            pcc_write(v, 1'b1);
            `CHK(processor_clock_ctrl_reg, v)
            `CHK(err, 1'b0)
            repeat (2100) @(posedge clk);
            window(i == 0 ? 16384 : (i < 6 ? 4096 : 13000));
            `CHK(near(c_pin, c_sys, 1), 1'b1)
            if (i < 6)
                `CHK(near(c_sys, (c_osc * CGP_PLL_MULT) >> i, 1), 1'b1)
            else
                `CHK(near(c_sys, r[8] ? c_rc : c_xt, 1), 1'b1)
            if (i >= 6)
                `CHK(near(c_sub, r[8] ? c_rc : c_xt, 1), 1'b1)
            if (i == 0) begin
                for (int k = 0; k <= CGP_PRE1_W; k++)
                    `CHK(near(c_pre1[k], (c_osc * 4) >> k, 1), 1'b1)
                for (int k = 0; k <= CGP_PRE4_W; k++)
                    `CHK(near(c_pre4[k], c_osc >> k, 1), 1'b1)
                `CHK(near(c_watch, c_osc * CGP_WATCH_HZ / CGP_FX_HZ, 1), 1'b1)
            end
        end
        pcc_write(8'h46, 1'b1);
        repeat (300) @(posedge clk);
        @(negedge clk);
        `CHK(main_osc_stop, 1'b1)
        window(200);
        `CHK(c_osc, 0)
        `CHK(c_main, 0)
        pcc_write(8'h06, 1'b1);
        @(negedge clk);
        `CHK(main_osc_stop, 1'b0)
        // the move off the subclock may wait two slow subclock periods
        pcc_write(8'h40, 1'b1);
        repeat (4100) @(posedge clk);
        @(negedge clk);
        `CHK(main_osc_stop, 1'b0)
        @(posedge clk);
        halt_mode <= 1'b1;
        @(negedge clk);
        `CHK(main_osc_stop, 1'b1)
        @(posedge clk);
        halt_mode <= 1'b0;
        // unkeyed write must bounce and leave the register alone
        pcc_write(8'h05, 1'b0);
        `CHK(err, 1'b1)
        `CHK(processor_clock_ctrl_reg, 8'h40)
        // selector code 7 is ignored, so the /1 ratio stays in force
        pcc_write(8'h07, 1'b1);
        repeat (64) @(posedge clk);
        window(512);
        `CHK(near(c_sys, c_osc * CGP_PLL_MULT, 1), 1'b1)
        report_and_stop();
    end
endmodule : tb_top
